// *** bench/qhp_host_model.sv ***
`timescale 1ns/100ps
`default_nettype none
module qhp_host_model (
    input  wire logic       clk_sys, // System clock.
    output logic            sep,     // Strap.
    output logic            rd_n,    // Read strobe.
    output logic            wr_n,    // Write strobe or direction.
    output logic [3:0]      cs_n,    // Selects A to D.
    output logic [2:0]      ra,      // Register address.
    output logic [7:0]      dq,      // Host side of data pins.
    input  wire logic [7:0] bus      // Resolved data pins.
);
    initial {sep, rd_n, wr_n, cs_n, ra, dq} = {3'h7, 4'hf, 11'h000};
    // Six clocks per phase keeps each strobe level above the four the port needs.
    task automatic xfer(input logic s, w, input logic [1:0] ch, input logic [2:0] a,
                        input logic [7:0] d, output logic [7:0] q);
        if (s !== sep) begin
            // Move the strap off the clock edge that ended the last transfer.
            #1 sep = s;
            repeat (8) @(posedge clk_sys);
        end
        @(posedge clk_sys) #1;
        ra = a;
        dq = w ? d : ~dq;
        cs_n = s ? ~(4'h1 << ch) : {d[0], ch, 1'b1};
        wr_n = s | ~w;
        @(posedge clk_sys) #1;
        if (!s) {cs_n[0], rd_n} = {1'b0, d[1]};
        else if (w) wr_n = 1'b0;
        else rd_n = 1'b0;
        repeat (6) @(posedge clk_sys);
        #1 q = bus;
        {rd_n, cs_n[0]} = {1'b1, ~s | cs_n[0]};
        wr_n = s | wr_n;
        repeat (6) @(posedge clk_sys);
        #1 {cs_n, wr_n, dq} = {5'h1f, ~dq};
        repeat (6) @(posedge clk_sys);
    endtask
endmodule // qhp_host_model
`default_nettype wire

// *** bench/qhp_properties.sv ***
`timescale 1ns/100ps
`default_nettype none
module qhp_checker (
    input wire logic                       clk_sys,             // Clock.
    input wire logic                       srst,                // Reset.
    input wire logic                       bus_style_sel,       // Strap.
    input wire logic                       read_strobe_n,       // Read strobe.
    input wire logic                       chan_a_select_n,     // Select A.
    input wire logic                       data_oe,             // Drive enable.
    input wire logic                       wr_pulse,            // Write request.
    input wire logic                       rd_pulse,            // Read request.
    input wire logic [qhp_pkg::DATA_W-1:0] data_out,            // Read byte driven.
    input wire logic [qhp_pkg::DATA_W-1:0] rd_data              // Read byte fetched.
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (srst);
    a_read_drive: assert property (rd_pulse |=> data_oe && data_out == $past(rd_data))
        else $error("read byte not driven");
    a_oe_cause: assert property ($rose(data_oe) |-> $past(rd_pulse))
        else $error("bus driven without read");
    a_wr_once: assert property (wr_pulse |=> !wr_pulse)
        else $error("write pulse too long");
    a_rd_once: assert property (rd_pulse |=> !rd_pulse)
        else $error("read pulse too long");
    a_no_clash: assert property (!(wr_pulse && rd_pulse))
        else $error("read and write together");
    a_strobe_ignored: assert property ((!bus_style_sel && chan_a_select_n) [*8] |-> !rd_pulse)
        else $error("read strobe used");
    a_read_quiet: assert property ((bus_style_sel && read_strobe_n && chan_a_select_n) [*8] |-> !rd_pulse)
        else $error("read without strobe");
    a_oe_release: assert property ((read_strobe_n && chan_a_select_n) [*6] |-> !data_oe)
        else $error("bus not released");
endmodule // qhp_checker
bind qhp_host_port qhp_checker qhp_checker_inst (.clk_sys, .srst, .bus_style_sel, .read_strobe_n,
    .chan_a_select_n, .data_oe, .wr_pulse, .rd_pulse, .data_out, .rd_data);
`default_nettype wire

// *** bench/tb.sv ***
`timescale 1ns/100ps
`default_nettype none
module tb;
    logic clk_sys = 0, srst = 1, sep, rd_n, wr_n, data_oe, wr_pulse, rd_pulse;
    logic [3:0] cs_n;
    logic [2:0] ra;
    logic [7:0] dq, bus, data_out, rd_data, q;
    logic [13:0] got;
    qhp_pkg::qhp_req_t req;
    int n_mismatch = 0, checks_done = 0, n_ev = 0, n0;
    always #2 clk_sys = ~clk_sys;
    function automatic logic [7:0] reg_val(logic [1:0] c, logic [2:0] a);
        return {c, a, 3'h5} ^ 8'h96;
    endfunction
    assign rd_data = reg_val(req.chan, req.reg_addr);
    assign bus = data_oe ? data_out : dq;
    always @(posedge clk_sys) if (wr_pulse === 1'b1 || rd_pulse === 1'b1) begin
        n_ev++;
        got = {wr_pulse, req};
    end
    qhp_host_model qhp_host_model_inst (.clk_sys, .sep, .rd_n, .wr_n, .cs_n, .ra, .dq, .bus);
    qhp_host_port qhp_host_port_inst (.clk_sys, .srst, .bus_style_sel(sep), .read_strobe_n(rd_n),
        .write_strobe_n(wr_n), .chan_a_select_n(cs_n[0]), .chan_b_select_n(cs_n[1]),
        .chan_c_select_n(cs_n[2]), .chan_d_select_n(cs_n[3]), .reg_addr_bit2(ra[2]),
        .reg_addr_bit1(ra[1]), .reg_addr_bit0(ra[0]), .data_in(bus), .data_out, .data_oe,
        .wr_pulse, .rd_pulse, .req, .rd_data);
    task automatic chk(string nm, logic [7:0] g, logic [7:0] e);
        checks_done++;
        if (g !== e) begin
            n_mismatch++;
            $display("MISMATCH %s exp %h got %h", nm, e, g);
        end
    endtask
    task automatic close_out;
        if (n_mismatch == 0 && checks_done > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    task automatic run(logic s, w, logic [1:0] c, logic [2:0] a, logic [7:0] d);
        n0 = n_ev;
        qhp_host_model_inst.xfer(s, w, c, a, d, q);
        chk("events", 8'(n_ev - n0), 8'h01);
        chk("kind_addr_chan", {2'h0, got[13:8]}, {2'h0, w, a, c});
        if (w) chk("wdata", got[7:0], d);
        else chk("rdata", q, reg_val(c, a));
    endtask
    initial begin
        void'($urandom(67));
        repeat (6) @(posedge clk_sys);
        #1 srst = 0;
        for (int i = 0; i < 4; i++) begin
            run(1'b1, 1'b0, 2'(i), 3'h7, 8'hff);
            run(1'b0, 1'b1, 2'(i), 3'h0, 8'h00);
        end
        repeat (40) run(1'($urandom), 1'($urandom), 2'($urandom), 3'($urandom), 8'($urandom));
        close_out;
    end
    initial begin
        #50000 n_mismatch++;
        close_out;
    end
endmodule // tb
`default_nettype wire

// *** core/qhp_host_port.sv ***
`timescale 1ns/100ps
`default_nettype none
// Device-side host bus port. Pins are sampled through two flops on clk_sys; a
// transfer is detected on the synchronised strobe edges, or select A edges in single-select style. Internal register
// access leaves the block as one-cycle write/read pulses with channel and address.
module qhp_host_port (
    input  wire logic                         clk_sys,          // System clock.
    input  wire logic                         srst,             // Synchronous reset.
    input  wire logic                         bus_style_sel,    // Strap: 1 separate strobes.
    input  wire logic                         read_strobe_n,    // Read strobe pin.
    input  wire logic                         write_strobe_n,   // Write strobe or direction.
    input  wire logic                         chan_a_select_n,  // Select A or device select.
    input  wire logic                         chan_b_select_n,  // Select B or channel_addr_lo.
    input  wire logic                         chan_c_select_n,  // Select C or channel_addr_hi.
    input  wire logic                         chan_d_select_n,  // Select D.
    input  wire logic                         reg_addr_bit2,    // Register address bit 2.
    input  wire logic                         reg_addr_bit1,    // Register address bit 1.
    input  wire logic                         reg_addr_bit0,    // Register address bit 0.
    input  wire logic [qhp_pkg::DATA_W-1:0]   data_in,          // Data pins, input side.
    output logic      [qhp_pkg::DATA_W-1:0]   data_out,         // Data pins, output side.
    output logic                              data_oe,          // High while driving data.
    output logic                              wr_pulse,         // One-cycle register write.
    output logic                              rd_pulse,         // One-cycle register read.
    output qhp_pkg::qhp_req_t                 req,              // Channel, address, data.
    input  wire logic [qhp_pkg::DATA_W-1:0]   rd_data           // Read byte, same cycle as rd_pulse.
);
    localparam int NP = 7 + qhp_pkg::REG_AW + qhp_pkg::DATA_W;

    logic [NP-1:0] sync1_r;
    logic [NP-1:0] sync2_r;
    logic [NP-1:0] prev_r;
    logic          mode_r;
    logic [qhp_pkg::DATA_W-1:0] data_out_r;
    logic          data_oe_r;
    logic          wr_pulse_r;
    logic          rd_pulse_r;
    qhp_pkg::qhp_req_t req_r;
    logic          ss_rd_r;

    wire [NP-1:0] pins = {bus_style_sel, read_strobe_n, write_strobe_n, chan_a_select_n,
                          chan_b_select_n, chan_c_select_n, chan_d_select_n,
                          reg_addr_bit2, reg_addr_bit1, reg_addr_bit0, data_in};

    wire       s_style  = sync2_r[NP-1];
    wire       s_rd_n   = sync2_r[NP-2];
    wire       s_wr_n   = sync2_r[NP-3];
    wire [3:0] s_cs_n   = sync2_r[NP-4 -: 4];
    wire [qhp_pkg::REG_AW-1:0] s_addr = sync2_r[qhp_pkg::DATA_W +: qhp_pkg::REG_AW];
    wire [qhp_pkg::DATA_W-1:0] s_data = sync2_r[qhp_pkg::DATA_W-1:0];
    wire       p_rd_n   = prev_r[NP-2];
    wire       p_wr_n   = prev_r[NP-3];
    wire       p_csa_n  = prev_r[NP-4];

    // Separate-strobe channel decode; more than one select is a host fault and
    // the lowest channel wins.
    function automatic logic [qhp_pkg::CHAN_W-1:0] sel_chan(input logic [3:0] cs_n);
        if (!cs_n[3])      sel_chan = 2'h0;  // RL8
        else if (!cs_n[2]) sel_chan = 2'h1;  // RL8
        else if (!cs_n[1]) sel_chan = 2'h2;  // RL8
        else               sel_chan = 2'h3;  // RL12
    endfunction

    wire       sep_any  = ~&s_cs_n;                                  // RL8 RL12 RL14
    wire [1:0] sep_chan = sel_chan(s_cs_n);
    wire [1:0] ss_chan  = {s_cs_n[1], s_cs_n[2]};                    // RL10 RL13
    wire [1:0] chan     = mode_r ? sep_chan : ss_chan;               // RL9
    // Separate style: read at strobe fall, write at strobe rise.
    wire sep_rd_fall = mode_r & sep_any & p_rd_n & ~s_rd_n;          // RL3
    wire sep_rd_rise = mode_r & ~p_rd_n & s_rd_n;                    // RL4
    wire sep_wr_rise = mode_r & sep_any & ~p_wr_n & s_wr_n;          // RL5
    // Single-select style: the select framing the cycle; read strobe unused.
    wire ss_fall  = ~mode_r & p_csa_n & ~s_cs_n[3];                  // RL6 RL9
    wire ss_rise  = ~mode_r & ~p_csa_n & s_cs_n[3];
    wire ss_rd    = ss_fall & s_wr_n;                                // RL7
    wire ss_wr    = ss_rise & ~p_wr_n & ~ss_rd_r;                    // RL7
    wire do_rd    = sep_rd_fall | ss_rd;
    wire do_wr    = sep_wr_rise | ss_wr;
    wire rel_rd   = sep_rd_rise | (ss_rise & ss_rd_r) | (mode_r & s_rd_n & ~sep_any);

    always_ff @(posedge clk_sys) begin
        sync1_r <= pins;
        sync2_r <= sync1_r;
        prev_r  <= sync2_r;
    end

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            mode_r     <= 1'b1;
            data_out_r <= 8'h00;
            data_oe_r  <= 1'b0;
            wr_pulse_r <= 1'b0;
            rd_pulse_r <= 1'b0;
            req_r      <= '0;
            ss_rd_r    <= 1'b0;
        end else begin
            // Style only changes while the bus is idle so a cycle is never split.
            if (!data_oe_r && s_rd_n && s_cs_n[3] && &s_cs_n)
                mode_r <= s_style;                                   // RL1 RL6
            wr_pulse_r <= do_wr;                                     // RL5
            rd_pulse_r <= do_rd;                                     // RL3
            if (do_rd || do_wr)
                req_r <= '{reg_addr: s_addr, chan: chan, data: s_data}; // RL2
            if (do_rd)
                ss_rd_r <= ~mode_r;
            else if (ss_rise)
                ss_rd_r <= 1'b0;
            if (rd_pulse_r) begin
                data_out_r <= rd_data;                               // RL11
                data_oe_r  <= 1'b1;                                  // RL11
            end else if (rel_rd) begin
                data_oe_r  <= 1'b0;                                  // RL11
            end
        end
    end

    assign data_out = data_out_r;
    assign data_oe  = data_oe_r;
    assign wr_pulse = wr_pulse_r;
    assign rd_pulse = rd_pulse_r;
    assign req      = req_r;
endmodule // qhp_host_port
`default_nettype wire

// *** core/qhp_pkg.sv ***
// Functional notes
// RL1: Strap high selects separate read/write strobes and one select per channel.
// RL2: Three register address inputs pick the register inside the chosen channel.
// RL3: Separate-strobe read strobe falling edge starts a read; device drives byte.
// RL4: Host captures read byte at the read strobe rising edge.
// RL5: Write strobe fall begins write; rise latches bus byte into register.
// RL6: With strap low the read strobe input is ignored; the code waits for read strobe high before leaving separate style.
// RL7: Single-select style: write strobe pin is direction, high read, low write.
// RL8: Separate-strobe style: selects A, B, C each enable only their channel.
// RL9: Single-select style: channel A select is the one device select.
// RL10: Single-select style: B and C selects become two channel address lines.
// RL11: Eight-bit bidirectional data bus, driven only while returning read data.
// RL12: Channel D select enables channel D only in separate-strobe style.
// RL13: Channel address lines decode 00,01,10,11 to channels A,B,C,D.
// RL14: Host asserts one select at most and never both strobes together.
package qhp_pkg;
    localparam int NUM_CHAN   = 4;
    localparam int REG_AW     = 3;
    localparam int DATA_W     = 8;
    localparam int CHAN_W     = 2;
    localparam int SYNC_DEPTH = 2;

    typedef struct packed {
        logic [qhp_pkg::REG_AW-1:0] reg_addr;
        logic [qhp_pkg::CHAN_W-1:0] chan;
        logic [qhp_pkg::DATA_W-1:0] data;
    } qhp_req_t;
endpackage
